// file: design/embi_top.sv
// What this block does
// - 32-bit three-state data bus, bit 31 top
// - Pending output low while bus lent away and a transfer is queued
// - Sample map pins; first two place memory
// - Four active-low byte lane selects
// - Write strobe low on writes only
// - Address strobe only with valid address
// - Data strobe gates read and write data
// - Cycle start pulses low per transaction
// - Direction high read, low write throughout
// - Bus request floats address, data, control
// - Acknowledge only after lines released
`timescale 1ns/1ps
`default_nettype none

module embi_top #(
  parameter int ADDR_W = embi_pkg::ADDR_W,
  parameter int DATA_W = embi_pkg::DATA_W
) (
  input  wire logic                  clock,
  input  wire logic                  nrst,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // External memory bus
  output logic      [ADDR_W-1:0]     extAddr,
  output logic                       extAddrOe,
  input  wire logic [DATA_W-1:0]     extDataIn,
  output logic      [DATA_W-1:0]     extDataOut,
  output logic                       extDataOe,
  output embi_pkg::embi_ctl_t        memCtl,
  output logic                       memCtlOe,
  input  wire logic                  sync_ready_n,
  input  wire logic                  bus_request_n,
  output logic                       bus_grant_ack_n,
  output logic                       ext_access_pending_n,
  input  wire logic                  mem_map_sel_0,
  input  wire logic                  mem_map_sel_1,
  input  wire logic                  mem_map_sel_2,
  output logic      [1:0]            memMapMode
);

  // ==========================================================
  // Elaboration checks
  if (DATA_W != 32)
    $error("embi_top: data path must be 32 bits wide");
  if (ADDR_W < 1 || ADDR_W > 32)
    $error("embi_top: address width must be 1 to 32");
  // Byte lanes must tile the data path with no gap or overlap
  if (embi_pkg::LANES * 8 != DATA_W)
    $error("embi_top: byte lanes must cover the data path");

  // ==========================================================
  // Helpers
  function automatic logic hitReg(input logic [11:0] a,
                                  input logic [11:0] off);
    hitReg = (a == off);
  endfunction

  // ==========================================================
  // State
  embi_pkg::embi_state_t state_r, state_nxt;
  logic [31:0]       ctrl_r, ctrl_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [31:0]       wdata_r, wdata_nxt;
  logic [31:0]       rdata_r, rdata_nxt;
  logic [3:0]        lanes_r, lanes_nxt;
  logic              rnw_r, rnw_nxt;
  logic              pend_r, pend_nxt;
  logic              done_r, done_nxt;
  logic [2:0]        map_r, map_nxt;
  logic              mapTaken_r, mapTaken_nxt;
  logic              apbWr, apbRd, cmdGo, doneClr, busy, mapped;
  logic [31:0]       laneData;
  logic [31:0]       prdata_nxt;

  // Byte lanes that were not selected read back as zero
  genvar g;
  for (g = 0; g < embi_pkg::LANES; g++) begin : gLane
    assign laneData[g*8 +: 8] = lanes_r[g] ? extDataIn[g*8 +: 8]
                                           : 8'h00;
  end

  // ==========================================================
  // APB access decode
  assign apbWr   = psel && penable && pwrite;
  // Reads are looked up at the end of setup so prdata leaves a flop
  assign apbRd   = psel && !penable && !pwrite;
  // Lending the bus is not busy: a command may queue behind the lender
  assign busy    = pend_r || (state_r == embi_pkg::ST_START) ||
                   (state_r == embi_pkg::ST_WAIT) ||
                   (state_r == embi_pkg::ST_END);
  assign cmdGo   = apbWr && hitReg(paddr, embi_pkg::OFF_CMD)
                   && pwdata[embi_pkg::CMD_GO_BIT] && !busy;
  assign doneClr = apbWr && hitReg(paddr, embi_pkg::OFF_STAT)
                   && pwdata[embi_pkg::STAT_DONE];
  assign pready  = 1'b1;

  // Unmapped offsets and a command while busy both answer slverr
  always_comb begin
    mapped = 1'b1;
    if (hitReg(paddr, embi_pkg::OFF_CTRL)) begin
      mapped = 1'b1;
    end else if (hitReg(paddr, embi_pkg::OFF_ADDR)) begin
      mapped = 1'b1;
    end else if (hitReg(paddr, embi_pkg::OFF_WDATA)) begin
      mapped = 1'b1;
    end else if (hitReg(paddr, embi_pkg::OFF_CMD)) begin
      mapped = !(pwrite && busy);
    end else if (hitReg(paddr, embi_pkg::OFF_STAT)) begin
      mapped = 1'b1;
    end else if (hitReg(paddr, embi_pkg::OFF_RDATA)) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  assign pslverr = psel && penable && !mapped;

  // Read mux; caught at the setup edge so it stands through access.
  // Status is thus a snapshot one cycle old, harmless for polling.
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    if (apbRd && hitReg(paddr, embi_pkg::OFF_CTRL)) begin
      prdata_nxt = ctrl_r;
    end else if (apbRd && hitReg(paddr, embi_pkg::OFF_ADDR)) begin
      prdata_nxt[ADDR_W-1:0] = addr_r;
    end else if (apbRd && hitReg(paddr, embi_pkg::OFF_WDATA)) begin
      prdata_nxt = wdata_r;
    end else if (apbRd && hitReg(paddr, embi_pkg::OFF_CMD)) begin
      prdata_nxt[embi_pkg::CMD_RNW_BIT] = rnw_r;
      prdata_nxt[embi_pkg::CMD_LANE_LSB +: 4] = lanes_r;
    end else if (apbRd && hitReg(paddr, embi_pkg::OFF_STAT)) begin
      prdata_nxt[embi_pkg::STAT_BUSY] = busy;
      prdata_nxt[embi_pkg::STAT_DONE] = done_r;
      prdata_nxt[embi_pkg::STAT_HELD] = (state_r == embi_pkg::ST_HELD);
      prdata_nxt[embi_pkg::STAT_PEND] = !ext_access_pending_n;
      prdata_nxt[embi_pkg::STAT_MAP_LSB +: 3] = map_r;
    end else if (apbRd && hitReg(paddr, embi_pkg::OFF_RDATA)) begin
      prdata_nxt = rdata_r;
    end
  end

  // ==========================================================
  // Register file and sequencer next state
  always_comb begin
    state_nxt    = state_r;
    ctrl_nxt     = ctrl_r;
    addr_nxt     = addr_r;
    wdata_nxt    = wdata_r;
    rdata_nxt    = rdata_r;
    lanes_nxt    = lanes_r;
    rnw_nxt      = rnw_r;
    pend_nxt     = pend_r;
    done_nxt     = done_r;
    map_nxt      = map_r;
    mapTaken_nxt = 1'b1;

    // Straps are caught on the first edge after reset release
    if (!mapTaken_r) begin
      map_nxt = {mem_map_sel_2, mem_map_sel_1, mem_map_sel_0};
    end

    if (apbWr && hitReg(paddr, embi_pkg::OFF_CTRL)) begin
      ctrl_nxt = pwdata;
    end
    // Address and data are locked while a transfer is queued
    if (apbWr && hitReg(paddr, embi_pkg::OFF_ADDR) && !busy) begin
      addr_nxt = pwdata[ADDR_W-1:0];
    end
    if (apbWr && hitReg(paddr, embi_pkg::OFF_WDATA) && !busy) begin
      wdata_nxt = pwdata;
    end
    if (cmdGo) begin
      pend_nxt  = 1'b1;
      rnw_nxt   = pwdata[embi_pkg::CMD_RNW_BIT];
      lanes_nxt = pwdata[embi_pkg::CMD_LANE_LSB +: 4];
    end
    if (doneClr) begin
      done_nxt = 1'b0;
    end

    case (state_r)
      embi_pkg::ST_IDLE: begin
        // A bus request wins over a queued transfer
        if (!bus_request_n) begin
          state_nxt = embi_pkg::ST_REL;
        end else if (pend_r) begin
          state_nxt = embi_pkg::ST_START;
        end
      end
      embi_pkg::ST_START: begin
        pend_nxt  = 1'b0;
        state_nxt = embi_pkg::ST_WAIT;
      end
      embi_pkg::ST_WAIT: begin
        // Stretch until memory says it may complete
        if (!sync_ready_n) begin
          state_nxt = embi_pkg::ST_END;
          if (rnw_r) begin
            rdata_nxt = laneData;
          end
        end
      end
      embi_pkg::ST_END: begin
        done_nxt  = 1'b1;
        state_nxt = embi_pkg::ST_IDLE;
      end
      embi_pkg::ST_REL: begin
        // Lines went quiet on entry; grant on the next edge
        state_nxt = embi_pkg::ST_HELD;
      end
      embi_pkg::ST_HELD: begin
        if (bus_request_n) begin
          state_nxt = embi_pkg::ST_RESUME;
        end
      end
      embi_pkg::ST_RESUME: begin
        // Drive returns here, two cycles before any new cycle
        state_nxt = embi_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = embi_pkg::ST_IDLE;
      end
    endcase

    // A completion in the clearing cycle is kept
    if (state_r == embi_pkg::ST_END) begin
      done_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r    <= embi_pkg::ST_IDLE;
      ctrl_r     <= embi_pkg::CTRL_RST;
      addr_r     <= '0;
      wdata_r    <= 32'h0000_0000;
      rdata_r    <= 32'h0000_0000;
      lanes_r    <= 4'h0;
      rnw_r      <= 1'b1;
      pend_r     <= 1'b0;
      done_r     <= 1'b0;
      map_r      <= 3'h0;
      mapTaken_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      ctrl_r     <= ctrl_nxt;
      addr_r     <= addr_nxt;
      wdata_r    <= wdata_nxt;
      rdata_r    <= rdata_nxt;
      lanes_r    <= lanes_nxt;
      rnw_r      <= rnw_nxt;
      pend_r     <= pend_nxt;
      done_r     <= done_nxt;
      map_r      <= map_nxt;
      mapTaken_r <= mapTaken_nxt;
    end
  end

  // ==========================================================
  // Pin outputs, computed from the next state so they leave
  // flip-flops and line up with the state they belong to
  embi_pkg::embi_ctl_t ctl_nxt;
  logic              ctlOe_nxt, dataOe_nxt, ack_nxt, pendN_nxt;
  logic              inXfer, lent;
  logic [ADDR_W-1:0] extAddr_nxt;
  logic [31:0]       dOut_nxt;

  always_comb begin
    ctl_nxt     = embi_pkg::CTL_IDLE;
    inXfer      = (state_nxt == embi_pkg::ST_START) ||
                  (state_nxt == embi_pkg::ST_WAIT);
    lent        = (state_nxt == embi_pkg::ST_REL) ||
                  (state_nxt == embi_pkg::ST_HELD);
    // Floats while the bus is lent out
    ctlOe_nxt   = !lent;
    ack_nxt     = (state_nxt != embi_pkg::ST_HELD);
    pendN_nxt   = !(lent && pend_nxt);
    extAddr_nxt = addr_nxt;
    dOut_nxt    = wdata_nxt;
    // Write data only goes out during a write transaction
    dataOe_nxt  = inXfer && !rnw_nxt;
    if (inXfer) begin
      ctl_nxt.address_strobe_n = 1'b0;
      ctl_nxt.read_not_write   = rnw_nxt;
      ctl_nxt.byte_lane_sel_n  = ~lanes_nxt;
    end
    if (state_nxt == embi_pkg::ST_START) begin
      ctl_nxt.cycle_start_n = 1'b0;
    end
    if (state_nxt == embi_pkg::ST_WAIT) begin
      ctl_nxt.data_strobe_n      = 1'b0;
      ctl_nxt.mem_write_strobe_n = rnw_nxt;
    end
    // Shared pin: memory output enable or access pending
    if (ctrl_nxt[embi_pkg::CTRL_ROLE_BIT]) begin
      ctl_nxt.shared_pin_n = pendN_nxt;
    end else begin
      ctl_nxt.shared_pin_n = !((state_nxt == embi_pkg::ST_WAIT)
                               && rnw_nxt);
    end
  end

  // Registered pins and read data; everything floats-safe from reset.
  // Control keeps driving in reset so strobes never float undefined
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      memCtl               <= embi_pkg::CTL_IDLE;
      prdata               <= 32'h0000_0000;
      memCtlOe             <= 1'b1;
      extAddrOe            <= 1'b1;
      extAddr              <= '0;
      extDataOut           <= 32'h0000_0000;
      extDataOe            <= 1'b0;
      bus_grant_ack_n      <= 1'b1;
      ext_access_pending_n <= 1'b1;
    end else begin
      memCtl               <= ctl_nxt;
      prdata               <= prdata_nxt;
      memCtlOe             <= ctlOe_nxt;
      extAddrOe            <= ctlOe_nxt;
      extAddr              <= extAddr_nxt;
      extDataOut           <= dOut_nxt;
      extDataOe            <= dataOe_nxt;
      bus_grant_ack_n      <= ack_nxt;
      ext_access_pending_n <= pendN_nxt;
    end
  end

  // Region code from the first two map pins only
  assign memMapMode = map_r[1:0];

endmodule

`default_nettype wire

// file: design/embi_pkg.sv
`default_nettype none
package embi_pkg;

  // ==========================================================
  // Widths
  localparam int ADDR_W  = 22;
  localparam int DATA_W  = 32;
  localparam int LANES   = 4;
  localparam int MAP_W   = 3;
  localparam int APB_AW  = 12;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] OFF_CTRL  = 12'h000;
  localparam logic [11:0] OFF_ADDR  = 12'h004;
  localparam logic [11:0] OFF_WDATA = 12'h008;
  localparam logic [11:0] OFF_CMD   = 12'h00c;
  localparam logic [11:0] OFF_STAT  = 12'h010;
  localparam logic [11:0] OFF_RDATA = 12'h014;

  // ==========================================================
  // Field positions and reset values
  localparam int CTRL_ROLE_BIT = 8;
  localparam int CMD_GO_BIT    = 0;
  localparam int CMD_RNW_BIT   = 1;
  localparam int CMD_LANE_LSB  = 4;
  localparam int STAT_BUSY     = 0;
  localparam int STAT_DONE     = 1;
  localparam int STAT_HELD     = 2;
  localparam int STAT_PEND     = 3;
  localparam int STAT_MAP_LSB  = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_WAIT, ST_END, ST_REL, ST_HELD, ST_RESUME
  } embi_state_t;

  // Memory control pins, all active low except read_not_write
  typedef struct packed {
    logic [3:0] byte_lane_sel_n;
    logic       mem_write_strobe_n;
    logic       address_strobe_n;
    logic       data_strobe_n;
    logic       cycle_start_n;
    logic       read_not_write;
    logic       shared_pin_n;
  } embi_ctl_t;

  localparam embi_ctl_t CTL_IDLE = '{4'hf, 1'b1, 1'b1, 1'b1, 1'b1,
                                     1'b1, 1'b1};

endpackage
`default_nettype wire

// file: sim/embi_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Word-wide memory with adjustable ready delay
module embi_mem_model (
  input  wire logic                clock,
  input  wire embi_pkg::embi_ctl_t memCtl,
  input  wire logic [3:0]          addr,
  input  wire logic [31:0]         wrData,
  input  wire logic [3:0]          waitCycles,
  output logic      [31:0]         rdData,
  output logic                     readyN
);
  // Cleared at start so lanes never written read back as zero
  logic [31:0] mem [16] = '{default: 32'h0000_0000};
  logic [3:0]  cnt = 4'h0;
  logic        tgl = 1'b0;
  // Ready after the chosen number of data strobe cycles
  assign readyN = !(!memCtl.data_strobe_n && cnt == waitCycles);
  // Drive only while read data is invited; a moving pattern otherwise,
  // so a stale value can never pass for real data
  assign rdData = (!memCtl.data_strobe_n && memCtl.read_not_write) ?
                  mem[addr] : {32{tgl}} ^ 32'h5a5a_a5a5;
  // Store selected lanes when the write completes
  always @(posedge clock) begin
    tgl <= !tgl;
    cnt <= memCtl.data_strobe_n ? 4'h0 : cnt + 4'h1;
    if (!readyN && !memCtl.mem_write_strobe_n)
      for (int i = 0; i < 4; i++)
        if (!memCtl.byte_lane_sel_n[i])
          mem[addr][8*i +: 8] <= wrData[8*i +: 8];
  end
endmodule
`default_nettype wire

// file: sim/embi_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Memory bus and hand-over checks
module embi_top_chk (
  input wire logic                clock,
  input wire logic                nrst,
  input wire embi_pkg::embi_ctl_t memCtl,
  input wire logic                memCtlOe,
  input wire logic                extAddrOe,
  input wire logic                extDataOe,
  input wire logic                sync_ready_n,
  input wire logic                bus_grant_ack_n,
  input wire logic                ext_access_pending_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // One-cycle start, then the data phase opens
  sequence s_start;
    !memCtl.cycle_start_n ##1 (memCtl.cycle_start_n && !memCtl.data_strobe_n);
  endsequence
  start_pulse_a: assert property (
    $fell(memCtl.cycle_start_n) |-> s_start) else $error("bad start pulse");
  ds_addr_a: assert property (
    !memCtl.data_strobe_n |-> !memCtl.address_strobe_n)
    else $error("data strobe without address");
  wr_dir_a: assert property (
    !memCtl.mem_write_strobe_n |-> !memCtl.read_not_write &&
    !memCtl.data_strobe_n) else $error("write strobe on read");
  ready_end_a: assert property (
    !memCtl.data_strobe_n && !sync_ready_n |=>
    memCtl.data_strobe_n && memCtl.address_strobe_n)
    else $error("no end after ready");
  wait_hold_a: assert property (
    !memCtl.data_strobe_n && sync_ready_n |=> !memCtl.data_strobe_n)
    else $error("ended without ready");
  dir_steady_a: assert property (
    !memCtl.address_strobe_n ##1 !memCtl.address_strobe_n |->
    $stable(memCtl.read_not_write)) else $error("direction moved");
  bus_release_a: assert property (
    !bus_grant_ack_n |-> !memCtlOe && !extAddrOe && !extDataOe)
    else $error("driving while granted");
  ack_after_a: assert property (
    $fell(memCtlOe) |=> !bus_grant_ack_n) else $error("late grant");
  drive_resume_a: assert property (
    $rose(bus_grant_ack_n) |-> memCtlOe ##1 memCtl.cycle_start_n)
    else $error("bad resume");
  pend_owner_a: assert property (
    !ext_access_pending_n |-> !memCtlOe) else $error("pending while owner");
  shared_role_a: assert property (
    !memCtl.shared_pin_n |-> (!memCtl.data_strobe_n &&
    memCtl.read_not_write) || !ext_access_pending_n)
    else $error("shared pin low without cause");
endmodule
bind embi_top embi_top_chk u_chk (.clock(clock), .nrst(nrst),
  .memCtl(memCtl), .memCtlOe(memCtlOe), .extAddrOe(extAddrOe),
  .extDataOe(extDataOe), .sync_ready_n(sync_ready_n),
  .bus_grant_ack_n(bus_grant_ack_n),
  .ext_access_pending_n(ext_access_pending_n));
`default_nettype wire

// file: sim/external_memory_bus_interface_test.sv
`timescale 1ns/1ps
`default_nettype none
module external_memory_bus_interface_test;
  logic                clock = 1'b0;
  logic                nrst = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic                busReqN = 1'b1;
  logic [11:0]         paddr = 12'h000;
  logic [31:0]         pwdata = 32'h0000_0000;
  logic [3:0]          waitCycles = 4'h3;
  logic [31:0]         prdata, mdlData, rd, extDataOut;
  logic [21:0]         extAddr;
  logic [1:0]          memMapMode;
  logic                pready, pslverr, err, extAddrOe, extDataOe;
  logic                memCtlOe, readyN, ackN, pendN;
  embi_pkg::embi_ctl_t memCtl;
  int                  miscompares = 0;
  int                  n_tests = 0;
  // ========================================================
  // Clock, design and memory
  always #2 clock = ~clock;
  embi_top u_embi_top (.clock(clock), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extAddr(extAddr), .extAddrOe(extAddrOe),
    .extDataIn(extDataOe ? extDataOut : mdlData),
    .extDataOut(extDataOut), .extDataOe(extDataOe), .memCtl(memCtl),
    .memCtlOe(memCtlOe), .sync_ready_n(readyN),
    .bus_request_n(busReqN), .bus_grant_ack_n(ackN),
    .ext_access_pending_n(pendN), .mem_map_sel_0(1'b1),
    .mem_map_sel_1(1'b0), .mem_map_sel_2(1'b1), .memMapMode(memMapMode));
  // Released control lines float to their pulled-up idle level
  embi_mem_model u_embi_mem_model (.clock(clock),
    .memCtl(memCtlOe ? memCtl : embi_pkg::CTL_IDLE),
    .addr(extAddr[3:0]), .wrData(extDataOut), .waitCycles(waitCycles),
    .rdData(mdlData), .readyN(readyN));
  // ========================================================
  // Shared tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task complete_run;
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Request stands until pready is seen high at a rising edge; read data
  // and error are taken at that edge, before the design updates
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_done;
    do xfer(embi_pkg::OFF_STAT, 1'b0, 32'h0); while (rd[1] !== 1'b1);
    xfer(embi_pkg::OFF_STAT, 1'b1, 32'h2);
  endtask
  // ========================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check({28'h0, memMapMode, ackN, pendN}, 32'h7);
    // Slow write of lanes 0, 2, 3 including the top data line
    xfer(embi_pkg::OFF_ADDR, 1'b1, 32'h5);
    xfer(embi_pkg::OFF_WDATA, 1'b1, 32'h9122_3344);
    xfer(embi_pkg::OFF_CMD, 1'b1, 32'hd1);
    wait_done;
    waitCycles <= 4'h0;
    xfer(embi_pkg::OFF_CMD, 1'b1, 32'hf3);
    wait_done;
    xfer(embi_pkg::OFF_RDATA, 1'b0, 32'h0);
    check(rd, 32'h9122_0044);
    xfer(embi_pkg::OFF_CMD, 1'b1, 32'h33);
    wait_done;
    xfer(embi_pkg::OFF_RDATA, 1'b0, 32'h0);
    check(rd, 32'h0000_0044);
    xfer(12'h018, 1'b0, 32'h0);
    check({err, rd[30:0]}, 32'h8000_0000);
    // Lend the bus, queue a read that must wait for the return
    xfer(embi_pkg::OFF_CTRL, 1'b1, 32'h100);
    busReqN <= 1'b0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    check({ackN, memCtlOe, extAddrOe, extDataOe}, 32'h0);
    xfer(embi_pkg::OFF_CMD, 1'b1, 32'hf3);
    repeat (3) @(posedge clock);
    @(negedge clock);
    check({pendN, memCtl.shared_pin_n, ackN}, 32'h0);
    @(posedge clock);
    busReqN <= 1'b1;
    wait_done;
    xfer(embi_pkg::OFF_RDATA, 1'b0, 32'h0);
    check({rd[31:1], pendN}, 32'h9122_0045);
    complete_run;
  end
  // A hang counts against the run
  initial begin
    repeat (10000) @(posedge clock);
    miscompares++;
    complete_run;
  end
endmodule
`default_nettype wire
